// ===== logic/wse_top.sv
// work station error encoder: classifies terminal faults into status bytes, apb slave
// assumes all event inputs are synchronous to MCLK and strobes last one cycle
`timescale 1ns/1ps
`include "wse_params.svh"
module wse_top #(
   parameter int unsigned EO_LIMIT = `WSE_EO_TIME_MS * `WSE_CLK_KHZ
) (
   input  wire logic              MCLK,
   input  wire logic              RSTN,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [7:0]        PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic                   PREADY,
   output logic [31:0]            PRDATA,
   output logic                   PSLVERR,
   input  wire wse_pkg::wse_cmd_s CMD,
   input  wire logic              CMD_DONE,
   input  wire wse_pkg::wse_cf_s  CF_FAULT,
   input  wire wse_pkg::wse_term_s TERM,
   input  wire wse_pkg::wse_fmt_s FMT,
   input  wire wse_pkg::wse_poll_s POLL,
   input  wire logic              TX_RECOVER,
   input  wire logic              EO_LEVEL,
   input  wire wse_pkg::wse_code_s REJECT,
   input  wire wse_pkg::wse_code_s SCAN_BAD,
   input  wire logic              MDT,
   output logic                   LOG_REQ,
   output logic                   POLL_BLOCK
);
   import wse_pkg::*;

   // first detail code found among flags, in priority order of the array
   function automatic logic [7:0] first_code(input logic [5:0] hit, input logic [47:0] codes);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 5; i >= 0; i--) begin
         if (hit[i]) begin
            c = codes[i*8 +: 8];
         end
      end
      return c;
   endfunction

   logic [31:0] ctrl, next_ctrl;
   logic [31:0] prdata_q, next_prdata;
   logic        pready_q, next_pready, pslverr_q, next_pslverr;
   logic [7:0]  host, next_host, cable, next_cable, devcab, next_devcab;
   logic [7:0]  ds0, next_ds0, ds1, next_ds1;
   logic        held, next_held, log_q, next_log, block, next_block;
   logic [3:0]  fails, next_fails;
   wse_seq_e    seq, next_seq;
   logic [24:0] eo_cnt, next_eo_cnt;
   logic        eo_last, next_eo_last;
   logic [15:0] busy_cnt, next_busy_cnt;
   logic        busy_run, next_busy_run;

   // bus decode; pready is registered from the setup cycle so every access completes with no wait state
   logic setup, access, rd_stat, rd_line, wr_ctrl, mapped;
   assign setup   = PSEL & ~PENABLE;
   assign access  = PSEL & PENABLE & pready_q;
   assign mapped  = (PADDR == `WSE_OFF_CTRL) | (PADDR == `WSE_OFF_STAT) |
                    (PADDR == `WSE_OFF_LINE);
   assign rd_stat = access & ~PWRITE & (PADDR == `WSE_OFF_STAT);
   assign rd_line = access & ~PWRITE & (PADDR == `WSE_OFF_LINE);
   assign wr_ctrl = access & PWRITE & (PADDR == `WSE_OFF_CTRL);

   // category hits: each six-bit flag vector, several bits possibly set, feeds first_code with its code table
   logic [5:0] cf_hit, ru_hit, sf_hit;
   logic       cf_any, ru_any, sf_any, seq_err, eo_tmo, busy_tmo, retry_out;
   always_comb begin
      cf_hit[0] = CF_FAULT.bad_modifier;
      cf_hit[1] = CF_FAULT.bad_count;
      cf_hit[2] = CF_FAULT.no_addr;
      // all three byte-count cases share code 04
      cf_hit[3] = CF_FAULT.count_underflow | CF_FAULT.count_nonzero | CF_FAULT.no_format;
      cf_hit[5:4] = 2'b00;
      // screen command needs a table command first; table mode rejects the read, read fields and other commands
      seq_err = CMD.valid & ((seq == SEQ_IDLE & (CMD.cmd == CMD_SCR_SAVE |
                CMD.cmd == CMD_SCR_RESTORE)) | (seq == SEQ_TABLE & (CMD.cmd == CMD_READ |
                CMD.cmd == CMD_READ_FIELDS | CMD.cmd == CMD_OTHER)));
      // power and session are checked before the rest
      ru_hit[0] = CMD.valid & ~TERM.powered;
      ru_hit[2] = CMD.valid & TERM.offline;
      ru_hit[1] = CMD.valid & TERM.nonop;
      // operator error mode, keyboard unlocked at read time
      ru_hit[3] = CMD.valid & TERM.operr_mode;
      ru_hit[4] = CMD.valid & ~TERM.kbd_locked &
                  (CMD.cmd == CMD_READ | CMD.cmd == CMD_READ_FIELDS);
      ru_hit[5] = seq_err;
      // zero length, no end attribute, one-byte signed, 80-column crossing
      sf_hit[0] = FMT.field_valid & ((FMT.read_len == 8'h00) | ~FMT.end_attr |
                  (FMT.signed_num & FMT.read_len == 8'h01) |
                  ((FMT.def_len > `WSE_LINE_CHARS) != (FMT.read_len > `WSE_LINE_CHARS)));
      sf_hit[1] = FMT.reseq_valid & ((FMT.reseq_num == 8'h00) | (FMT.reseq_num > FMT.nfields));
      sf_hit[2] = FMT.chk_valid & (FMT.chk_len > `WSE_CHKDIG_MAX);
      sf_hit[5:3] = 3'b000;
      cf_any = |cf_hit;
      ru_any = |ru_hit;
      sf_any = |sf_hit;
   end

   // retry budget taken from the control register
   assign retry_out = (fails >= ctrl[`WSE_RETRY_LSB +: 4]);
   assign eo_tmo    = ctrl[`WSE_EO_EN_BIT] & (eo_cnt == 25'(EO_LIMIT - 1));
   assign busy_tmo  = busy_run & (busy_cnt == ctrl[`WSE_BUSY_LSB +: 16]);

   // status bytes, detail codes, poll block and log request
   always_comb begin
      logic [7:0] h_set, c_set, d_set;
      h_set = {REJECT.valid, cf_any, ru_any, 5'b00000};
      c_set = 8'h00;
      d_set = 8'h00;
      next_fails = fails;
      next_seq = seq;
      if (POLL.done) begin
         if (POLL.no_resp | POLL.parity) begin
            if (retry_out) begin
               // timeout only once the retries are spent
               c_set |= POLL.no_resp ? `WSE_CAB_NORESP : 8'h00;
               // parity check after the last retry
               c_set |= POLL.parity ? `WSE_CAB_PAR : 8'h00;
               next_fails = 4'h0;
            end else begin
               next_fails = fails + 4'h1;
            end
         end else begin
            next_fails = 4'h0;
         end
         c_set |= POLL.tx_fail ? `WSE_CAB_TXCHK : 8'h00;
         c_set |= POLL.len_err ? `WSE_CAB_LEN : 8'h00;
         c_set |= POLL.act_fail ? `WSE_CAB_ACTF : 8'h00;
      end
      c_set |= sf_any ? `WSE_CAB_SF : 8'h00;
      c_set |= eo_tmo ? `WSE_CAB_EO : 8'h00;
      d_set |= busy_tmo ? `WSE_DEV_BUSY : 8'h00;
      // host summary bits; set wins over read clear
      next_host = (rd_stat ? 8'h00 : host) | h_set;
      next_cable = (rd_stat ? 8'h00 : cable) | c_set;
      next_devcab = (rd_line ? 8'h00 : devcab) | d_set;
      // only recorded bits request a log entry
      next_log = |(c_set & `WSE_CAB_LOGGED) | (|d_set);
      // polls stay blocked until the line recovers; a new failure beats the recover
      next_block = (TX_RECOVER ? 1'b0 : block) | (POLL.done & POLL.tx_fail);
      if (CMD.valid) begin
         if (CMD.cmd == CMD_TBL_SAVE | CMD.cmd == CMD_TBL_RESTORE) begin
            next_seq = SEQ_TABLE;
         end else if (CMD.cmd != CMD_CLEAR_UNIT & CMD.cmd != CMD_SCR_SAVE &
                      CMD.cmd != CMD_SCR_RESTORE) begin
            next_seq = SEQ_IDLE;
         end
      end
      // byte 0 and the scan bit of byte 1 freeze at the first fault until the status read
      next_held = rd_stat ? 1'b0 : held;
      next_ds0 = rd_stat ? 8'h00 : ds0;
      next_ds1 = rd_stat ? 8'h00 : ds1;
      if (!held) begin
         // one category fills byte 0, in fixed priority
         if (REJECT.valid) begin
            next_ds0 = {4'h0, REJECT.code[3:0]};
            next_held = 1'b1;
         end else if (cf_any) begin
            // table holds only 01 to 04
            next_ds0 = first_code(cf_hit, {16'h0000, `WSE_CF_UNDERFLOW, `WSE_CF_NO_ADDR,
                                           `WSE_CF_COUNT, `WSE_CF_MODIFIER});
            next_held = 1'b1;
         end else if (ru_any) begin
            next_ds0 = first_code({ru_hit[5], ru_hit[4], ru_hit[3], ru_hit[1], ru_hit[2],
                                   ru_hit[0]}, {`WSE_RU_SEQUENCE, `WSE_RU_KBD,
                                   `WSE_RU_OPERR, `WSE_RU_NONOP, `WSE_RU_OFFLINE,
                                   `WSE_RU_NO_POWER});
            next_held = 1'b1;
         end else if (sf_any) begin
            next_ds0 = first_code(sf_hit, {24'h000000, `WSE_SF_CHKDIG, `WSE_SF_RESEQ,
                                           `WSE_SF_FIELD});
            next_held = 1'b1;
         end else if (SCAN_BAD.valid) begin
            // byte 1 names the scan fault, byte 0 holds the code
            next_ds0 = SCAN_BAD.code;
            next_ds1 = (rd_stat ? 8'h00 : ds1) | `WSE_DS1_SCAN;
            next_held = 1'b1;
         end
      end
      // data tag is informational and never freezes byte 0
      // tag lands on bit 4 of byte 1
      if (MDT) begin
         next_ds1 = next_ds1 | `WSE_DS1_MDT;
      end
   end

   // timers for the even/odd level and the command processing limit
   always_comb begin
      next_eo_last = EO_LEVEL;
      next_eo_cnt = eo_cnt;
      // count restarts on each level change, held at zero when disabled
      if (!ctrl[`WSE_EO_EN_BIT] | (EO_LEVEL != eo_last) | eo_tmo) begin
         next_eo_cnt = 25'h0;
      end else begin
         next_eo_cnt = eo_cnt + 25'h1;
      end
      // timer armed by a command, stopped by done or by the timeout
      next_busy_run = busy_run;
      next_busy_cnt = busy_cnt;
      if (CMD.valid) begin
         next_busy_run = 1'b1;
         next_busy_cnt = 16'h0;
      end else if (CMD_DONE | busy_tmo) begin
         next_busy_run = 1'b0;
      end else if (busy_run) begin
         next_busy_cnt = busy_cnt + 16'h1;
      end
   end

   // apb slave: setup cycle loads data and pready, access edge commits
   always_comb begin
      next_ctrl = wr_ctrl ? PWDATA : ctrl;
      next_pready = setup;
      next_pslverr = setup & ~mapped;
      next_prdata = 32'h0;
      if (setup & ~PWRITE) begin
         unique case (PADDR)
            `WSE_OFF_CTRL: next_prdata = ctrl;
            `WSE_OFF_STAT: next_prdata = {ds1, ds0, cable, host};
            `WSE_OFF_LINE: next_prdata = {16'h0, fails, 3'b000, block, devcab};
            default:       next_prdata = 32'h0;
         endcase
      end
   end

   // register stage for all groups
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         ctrl <= `WSE_CTRL_RESET;
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         host <= 8'h00;
         cable <= 8'h00;
         devcab <= 8'h00;
         ds0 <= 8'h00;
         ds1 <= 8'h00;
         held <= 1'b0;
         log_q <= 1'b0;
         block <= 1'b0;
         fails <= 4'h0;
         seq <= SEQ_IDLE;
         eo_cnt <= 25'h0;
         eo_last <= 1'b0;
         busy_cnt <= 16'h0;
         busy_run <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         prdata_q <= next_prdata;
         pready_q <= next_pready;
         pslverr_q <= next_pslverr;
         host <= next_host;
         cable <= next_cable;
         devcab <= next_devcab;
         ds0 <= next_ds0;
         ds1 <= next_ds1;
         held <= next_held;
         log_q <= next_log;
         block <= next_block;
         fails <= next_fails;
         seq <= next_seq;
         eo_cnt <= next_eo_cnt;
         eo_last <= next_eo_last;
         busy_cnt <= next_busy_cnt;
         busy_run <= next_busy_run;
      end
   end

   assign PREADY = pready_q;
   assign PRDATA = prdata_q;
   assign PSLVERR = pslverr_q;
   assign LOG_REQ = log_q;
   assign POLL_BLOCK = block;

   // checks next to the logic they guard
   sequence bad_mod_s;
      CF_FAULT.bad_modifier & ~REJECT.valid & ~held & ~rd_stat;
   endsequence
   sequence last_retry_s;
      POLL.done & POLL.no_resp & retry_out & ~rd_stat;
   endsequence

   cf_code_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      bad_mod_s |=> ds0 == `WSE_CF_MODIFIER && host[6]) else $error("control field code wrong");
   cf_nolog_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      cf_any & ~POLL.done & ~sf_any & ~eo_tmo & ~busy_tmo |=> !LOG_REQ)
      else $error("control field error made a log request");
   noresp_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      POLL.done & POLL.no_resp & ~retry_out & ~rd_stat & ~cable[6] |=> !cable[6])
      else $error("timeout before retries were spent");
   noresp_log_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      last_retry_s |=> cable[6] && LOG_REQ && fails == 4'h0)
      else $error("timeout missing after last retry");
   txblock_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      POLL.done & POLL.tx_fail & ~TX_RECOVER |=> POLL_BLOCK throughout (~TX_RECOVER)[*3]
      or ##[0:2] TX_RECOVER) else $error("poll block dropped early");
   eo_cnt_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      ctrl[`WSE_EO_EN_BIT] & ($changed(EO_LEVEL)) |=> ##1 eo_cnt <= 25'h1)
      else $error("even odd timer not restarted");
   eo_max_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      eo_cnt < 25'(EO_LIMIT)) else $error("even odd timer overran its limit");
   busy_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      busy_tmo & ~rd_line |=> devcab[7] ##1 !busy_run) else $error("busy not flagged");
   cf_range_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      host[6] & ~host[7] & held & ~host[5] & ~cable[7] & ~ds1[5] |-> ds0 inside {[8'h01:8'h04]})
      else $error("unused control field code emitted");
   hold_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      held & ~rd_stat |=> $stable(ds0)) else $error("detail byte changed before read");
   scan_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      SCAN_BAD.valid & ~held & ~rd_stat & ~REJECT.valid & ~cf_any & ~ru_any & ~sf_any
      |=> ds1[5] && ds0 == $past(SCAN_BAD.code)) else $error("scan code not reported");
endmodule

// ===== common/wse_params.svh
// offsets, bit masks, detail codes and timing for the work station error encoder
// assumes an apb slave with 32-bit data and a 40 MHz MCLK
`ifndef WSE_PARAMS_SVH
`define WSE_PARAMS_SVH
// register byte offsets
`define WSE_OFF_CTRL      8'h00
`define WSE_OFF_STAT      8'h04
`define WSE_OFF_LINE      8'h08
// control register fields and reset value
`define WSE_CTRL_RESET    32'h0001_0013
`define WSE_RETRY_LSB     0
`define WSE_EO_EN_BIT     4
`define WSE_BUSY_LSB      8
// status byte bit masks, bit 0 is the most significant bit of a byte
`define WSE_HOST_DSR      8'h80
`define WSE_HOST_CF       8'h40
`define WSE_HOST_RU       8'h20
`define WSE_CAB_SF        8'h80
`define WSE_CAB_NORESP    8'h40
`define WSE_CAB_TXCHK     8'h20
`define WSE_CAB_ACTF      8'h10
`define WSE_CAB_PAR       8'h08
`define WSE_CAB_LEN       8'h04
`define WSE_CAB_EO        8'h01
`define WSE_CAB_LOGGED    8'h7D
`define WSE_DEV_BUSY      8'h80
`define WSE_DS1_SCAN      8'h20
`define WSE_DS1_MDT       8'h08
// detail codes for device status 0
`define WSE_CF_MODIFIER   8'h01
`define WSE_CF_COUNT      8'h02
`define WSE_CF_NO_ADDR    8'h03
`define WSE_CF_UNDERFLOW  8'h04
`define WSE_RU_NONOP      8'h02
`define WSE_RU_OFFLINE    8'h03
`define WSE_RU_OPERR      8'h05
`define WSE_RU_KBD        8'h06
`define WSE_RU_NO_POWER   8'h07
`define WSE_RU_SEQUENCE   8'h09
`define WSE_SF_FIELD      8'h01
`define WSE_SF_RESEQ      8'h02
`define WSE_SF_CHKDIG     8'h03
// field limits and timing
`define WSE_LINE_CHARS    8'd80
`define WSE_CHKDIG_MAX    8'd32
`define WSE_EO_TIME_MS    450
`define WSE_CLK_KHZ       40000
`endif

// ===== common/wse_pkg.sv
// types shared by the work station error encoder and its bench
// constants live in wse_params.svh
package wse_pkg;
   typedef enum logic [2:0] {CMD_CLEAR_UNIT, CMD_TBL_SAVE, CMD_TBL_RESTORE, CMD_SCR_SAVE,
                             CMD_SCR_RESTORE, CMD_READ, CMD_READ_FIELDS, CMD_OTHER} wse_cmd_e;
   typedef enum {SEQ_IDLE, SEQ_TABLE} wse_seq_e;
   typedef struct packed {logic valid; wse_cmd_e cmd;} wse_cmd_s;
   typedef struct packed {
      logic bad_modifier; logic bad_count; logic no_addr;
      logic count_underflow; logic count_nonzero; logic no_format;
   } wse_cf_s;
   typedef struct packed {
      logic nonop; logic offline; logic operr_mode; logic kbd_locked; logic powered;
   } wse_term_s;
   typedef struct packed {
      logic field_valid; logic [7:0] def_len; logic [7:0] read_len;
      logic signed_num; logic end_attr;
      logic reseq_valid; logic [7:0] reseq_num; logic [7:0] nfields;
      logic chk_valid; logic [7:0] chk_len;
   } wse_fmt_s;
   typedef struct packed {
      logic done; logic no_resp; logic tx_fail; logic parity; logic len_err; logic act_fail;
   } wse_poll_s;
   typedef struct packed {logic valid; logic [7:0] code;} wse_code_s;
endpackage

// ===== verif/wse_term_model.sv
// terminal stand-in: completes commands and alternates its even/odd level
// assumes it shares MCLK with the encoder
`timescale 1ns/1ps
module wse_term_model (
   input  wire logic              MCLK,
   input  wire wse_pkg::wse_cmd_s cmd,
   input  wire logic              slow,
   input  wire logic              eo_run,
   output logic                   cmd_done,
   output logic                   eo_level
);
   import wse_pkg::*;
   int left = 0;
   initial begin
      cmd_done = 1'b0;
      eo_level = 1'b0;
   end
   // done 2 cycles after a command, 20 when slow is set
   always @(posedge MCLK) begin
      cmd_done <= !cmd.valid && left == 1;
      if (cmd.valid)
         left <= slow ? 20 : 2;
      else if (left != 0)
         left <= left - 1;
   end
   // level alternates
   // toggles each cycle; eo_run low stalls it to provoke the timeout
   always @(posedge MCLK)
      eo_level <= eo_run ? !eo_level : eo_level;
endmodule

// ===== verif/tb_wse_top.sv
// self-checking bench for the work station error encoder
// assumes wse_term_model as terminal and EO_LIMIT cut to 50 cycles
`timescale 1ns/1ps
`include "wse_params.svh"
module tb_wse_top;
   import wse_pkg::*;
   logic        MCLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, TX_RECOVER = 0, MDT = 0;
   logic        slow = 0, eo_run = 1, e, PREADY, PSLVERR, CMD_DONE, EO_LEVEL, LOG_REQ, POLL_BLOCK;
   logic [7:0]  PADDR = 0;
   logic [31:0] PWDATA = 0, PRDATA, q;
   wse_cmd_s    CMD = '0;
   wse_cf_s     CF_FAULT = '0;
   wse_term_s   TERM = 5'h03;
   wse_fmt_s    FMT = '0;
   wse_poll_s   POLL = '0;
   wse_code_s   REJECT = '0, SCAN_BAD = '0;
   int          n_mismatch = 0, n_checks = 0, n_log = 0, cyc = 0, l0 = 0;
   // encoder and its terminal
   wse_top #(.EO_LIMIT(50)) i_dut (.MCLK(MCLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA),
      .PSLVERR(PSLVERR), .CMD(CMD), .CMD_DONE(CMD_DONE), .CF_FAULT(CF_FAULT), .TERM(TERM),
      .FMT(FMT), .POLL(POLL), .TX_RECOVER(TX_RECOVER), .EO_LEVEL(EO_LEVEL), .REJECT(REJECT),
      .SCAN_BAD(SCAN_BAD), .MDT(MDT), .LOG_REQ(LOG_REQ), .POLL_BLOCK(POLL_BLOCK));
   wse_term_model i_term (.MCLK(MCLK), .cmd(CMD), .slow(slow), .eo_run(eo_run),
      .cmd_done(CMD_DONE), .eo_level(EO_LEVEL));
   // clock, log pulse count, hang limit far past the expected 420 cycles
   always #12.5 MCLK = ~MCLK;
   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      if (LOG_REQ === 1'b1)
         n_log <= n_log + 1;
      if (cyc == 6000) begin
         n_mismatch = n_mismatch + 1;
         conclude();
      end
   end
   // verdict and end of run
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // compare and count; a mismatch is reported at once
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // apb transfer: setup, then access held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      PSEL   <= 1'b1;
      PWRITE <= w;
      PADDR  <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do @(posedge MCLK); while (PREADY !== 1'b1);
      q = PRDATA;
      e = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   // read a register and compare the masked word
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q & m, x);
   endtask
   // reset values, read-only status, unmapped address
   task automatic t_reset();
      repeat (12) @(posedge MCLK);
      RSTN <= 1'b1;
      rc(`WSE_OFF_CTRL, '1, `WSE_CTRL_RESET);
      apb(1'b1, `WSE_OFF_STAT, 32'hFFFF_FFFF);
      rc(`WSE_OFF_STAT, '1, 32'h0);
      rc(8'h10, '1, 32'h0);
      chk({31'h0, e}, 32'h1);
   endtask
   // each control-field cause, cleared by the read
   task automatic t_cf();
      logic [7:0] x [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h04, 8'h04};
      l0 = n_log;
      for (int i = 0; i < 6; i++) begin
         CF_FAULT <= wse_cf_s'(6'h20 >> i);
         @(posedge MCLK);
         CF_FAULT <= '0;
         rc(`WSE_OFF_STAT, '1, {8'h00, x[i], 8'h00, `WSE_HOST_CF});
      end
   endtask
   // terminal states and command orders that make resources unavailable
   task automatic t_ru();
      wse_term_s  t [12] = '{5'h02, 5'h13, 5'h0B, 5'h07, 5'h01, 5'h03, 5'h03, 5'h03, 5'h03,
                             5'h03, 5'h03, 5'h03};
      wse_cmd_e   c [12] = '{CMD_OTHER, CMD_OTHER, CMD_OTHER, CMD_OTHER, CMD_READ,
                             CMD_SCR_RESTORE, CMD_TBL_SAVE, CMD_SCR_SAVE, CMD_READ_FIELDS,
                             CMD_TBL_RESTORE, CMD_CLEAR_UNIT, CMD_OTHER};
      logic [7:0] x [12] = '{8'h07, 8'h02, 8'h03, 8'h05, 8'h06, 8'h09, 8'h00, 8'h00, 8'h09,
                             8'h00, 8'h00, 8'h09};
      logic [7:0] h;
      for (int i = 0; i < 12; i++) begin
         TERM <= t[i];
         CMD  <= '{1'b1, c[i]};
         @(posedge MCLK);
         CMD  <= '0;
         h = (x[i] != 8'h00) ? `WSE_HOST_RU : 8'h00;
         rc(`WSE_OFF_STAT, '1, {8'h00, x[i], 8'h00, h});
      end
      TERM <= 5'h03;
   endtask
   // one format strobe; screen-format bit expected when x is nonzero
   task automatic sf(input wse_fmt_s v, input logic [7:0] x);
      FMT <= v;
      @(posedge MCLK);
      FMT <= '0;
      rc(`WSE_OFF_STAT, '1, {8'h00, x, (x != 8'h00) ? `WSE_CAB_SF : 8'h00, 8'h00});
   endtask
   // format faults beside the smallest and largest legal values
   task automatic t_sf();
      sf('{1, 0, 0, 0, 1, 0, 0, 0, 0, 0}, `WSE_SF_FIELD);
      sf('{1, 81, 79, 0, 1, 0, 0, 0, 0, 0}, `WSE_SF_FIELD);
      sf('{1, 80, 80, 0, 1, 0, 0, 0, 0, 0}, 8'h00);
      sf('{0, 0, 0, 0, 0, 1, 0, 5, 0, 0}, `WSE_SF_RESEQ);
      sf('{0, 0, 0, 0, 0, 1, 6, 5, 0, 0}, `WSE_SF_RESEQ);
      sf('{0, 0, 0, 0, 0, 0, 0, 0, 1, 33}, `WSE_SF_CHKDIG);
      sf('{0, 0, 0, 0, 0, 0, 0, 0, 1, 32}, 8'h00);
      chk(32'(n_log - l0), 32'h0);
   endtask
   // reject outranks control field; scan code and data tag together
   task automatic t_misc();
      REJECT   <= '{1'b1, 8'h0C};
      CF_FAULT <= wse_cf_s'(6'h20);
      @(posedge MCLK);
      REJECT   <= '0;
      CF_FAULT <= '0;
      rc(`WSE_OFF_STAT, '1, {16'h000C, 8'h00, `WSE_HOST_DSR | `WSE_HOST_CF});
      SCAN_BAD <= '{1'b1, 8'h5A};
      MDT      <= 1'b1;
      @(posedge MCLK);
      SCAN_BAD <= '0;
      MDT      <= 1'b0;
      rc(`WSE_OFF_STAT, '1, {`WSE_DS1_SCAN | `WSE_DS1_MDT, 8'h5A, 16'h0});
   endtask
   // quiet while the level toggles, flagged once it stalls past 50 cycles
   task automatic t_eo();
      apb(1'b1, `WSE_OFF_CTRL, 32'h0000_0813);
      rc(`WSE_OFF_CTRL, '1, 32'h0000_0813);
      repeat (120) @(posedge MCLK);
      rc(`WSE_OFF_STAT, '1, 32'h0);
      eo_run <= 1'b0;
      repeat (70) @(posedge MCLK);
      eo_run <= 1'b1;
      rc(`WSE_OFF_STAT, '1, {16'h0, `WSE_CAB_EO, 8'h00});
   endtask
   // retry limit 1: first failure silent, second flags and logs
   task automatic t_poll();
      wse_poll_s  p [2] = '{6'h30, 6'h24};
      logic [7:0] m [2] = '{`WSE_CAB_NORESP, `WSE_CAB_PAR};
      apb(1'b1, `WSE_OFF_CTRL, 32'h0000_0801);
      for (int i = 0; i < 4; i++) begin
         l0 = n_log;
         POLL <= p[i / 2];
         @(posedge MCLK);
         POLL <= '0;
         rc(`WSE_OFF_STAT, '1, {16'h0, (i % 2) ? m[i / 2] : 8'h00, 8'h00});
         chk(32'(n_log - l0), 32'(i % 2));
      end
      POLL <= 6'h22;
      @(posedge MCLK);
      POLL <= 6'h28;
      @(posedge MCLK);
      POLL <= '0;
      @(posedge MCLK);
      chk({31'h0, POLL_BLOCK}, 32'h1);
      rc(`WSE_OFF_STAT, '1, {16'h0, `WSE_CAB_LEN | `WSE_CAB_TXCHK, 8'h00});
      TX_RECOVER <= 1'b1;
      @(posedge MCLK);
      TX_RECOVER <= 1'b0;
      rc(`WSE_OFF_LINE, 32'h100, 32'h0);
   endtask
   // busy limit 8: a slow terminal overruns it, a prompt one does not
   task automatic t_busy();
      for (int i = 0; i < 2; i++) begin
         slow <= (i == 0);
         CMD  <= '{1'b1, CMD_OTHER};
         @(posedge MCLK);
         CMD  <= '0;
         repeat (25) @(posedge MCLK);
         rc(`WSE_OFF_LINE, 32'hFF, (i == 0) ? 32'h80 : 32'h0);
      end
   endtask
   // main sequence
   initial begin
      t_reset();
      t_cf();
      t_ru();
      t_sf();
      t_misc();
      t_eo();
      t_poll();
      t_busy();
      conclude();
   end
endmodule
